// >>> design/afic_param_mem.sv
`timescale 1ns/100ps
`default_nettype none
module afic_param_mem #(
   parameter int AW = 11,
   parameter int DW = 32
) (
   input  wire logic          CLK,
   input  wire logic          RESET,
   input  wire logic          WE,
   input  wire logic [AW-1:0] WADDR,
   input  wire logic [DW-1:0] WDATA,
   input  wire logic [AW-1:0] RADDR,
   output logic      [DW-1:0] RDATA
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   always_ff @(posedge CLK) begin
      if (WE) begin
         store[WADDR] <= WDATA;
      end
   end

   // read data registered; contents are undefined until written
   always_ff @(posedge CLK) begin
      if (RESET) begin
         RDATA <= '0;
      end else begin
         RDATA <= store[RADDR];
      end
   end
endmodule : afic_param_mem
`default_nettype wire

// >>> design/afic_top.sv
// How it works
// - frame: target, instruction, type, motor, value MSB first, checksum
// - instruction 34 copies accumulator into axis parameter type of motor
// - instruction 35 copies accumulator into global parameter type of bank
// - instruction 36 clears flags selected by type, ignoring motor and value
// - flag clear with type 0 clears every error flag
// - types 1..4 clear timeout, alarm, deviation, position flag only
// - type 5 clears only the shutdown flag
// - instruction 25 enables the interrupt numbered by type
// - instruction 25 with number 255 sets global interrupt enable
// - instruction 26 disables the interrupt numbered by type
// - instruction 26 with number 255 clears global interrupt enable
// - instruction 21 hex with type 2 multiplies accumulator by X
// - accumulator-with-X math takes X as operand, result to accumulator, except type 9, which copies accumulator into X, and type 10, which swaps the two
//   (types 3 and 4, divide and modulo, are not built here and are answered with status 3, bad type)
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "afic_defs.svh"
module afic_top #(
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter logic [7:0] HOST_ADDR   = 8'h02,
   parameter int         IRQ_COUNT   = 32
) (
   input  wire logic                  CLK,
   input  wire logic                  RESET,
   input  wire afic_pkg::afic_byte_t  RX_DATA,
   input  wire logic                  RX_VALID,
   output logic                       RX_READY,
   output afic_pkg::afic_byte_t       TX_DATA,
   output logic                       TX_VALID,
   input  wire logic                  TX_READY,
   input  wire logic [4:0]            FLAG_EVENT,
   output logic      [4:0]            ERR_FLAGS,
   output logic                       INT_GLOBAL_EN,
   output logic                       IRQ,
   input  wire logic [7:0]            S_AXI_AWADDR,
   input  wire logic                  S_AXI_AWVALID,
   output logic                       S_AXI_AWREADY,
   input  wire logic [31:0]           S_AXI_WDATA,
   input  wire logic [3:0]            S_AXI_WSTRB,
   input  wire logic                  S_AXI_WVALID,
   output logic                       S_AXI_WREADY,
   output logic      [1:0]            S_AXI_BRESP,
   output logic                       S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   input  wire logic [7:0]            S_AXI_ARADDR,
   input  wire logic                  S_AXI_ARVALID,
   output logic                       S_AXI_ARREADY,
   output logic      [31:0]           S_AXI_RDATA,
   output logic      [1:0]            S_AXI_RRESP,
   output logic                       S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY
);
   import afic_pkg::*;

   // --------------------
   // helpers
   // --------------------
   function automatic afic_byte_t byte_sum(input logic [71:0] f);
      afic_byte_t s;
      s = 8'h00;
      for (int i = 1; i < 9; i++) begin
         s = s + f[i*8 +: 8];
      end
      return s;
   endfunction : byte_sum

   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction : reg_hit

   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : strb_merge

   // --------------------
   // state
   // --------------------
   afic_state_t          state;
   afic_state_t          next_state;
   afic_frame_t          frm;
   logic [3:0]           rx_cnt;
   logic [3:0]           tx_cnt;
   logic [63:0]          tx_buf;
   logic [31:0]          accu;
   logic [31:0]          xreg;
   logic [IRQ_COUNT-1:0] irq_en;
   logic [4:0]           flag_meta;
   logic [4:0]           flag_sync;
   logic [10:0]          paddr;
   logic [31:0]          pdata;
   logic [2:0]           stat;
   logic [2:0]           mask;
   logic                 aw_full;
   logic                 w_full;
   logic [7:0]           aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;

   wire rx_take = RX_VALID && RX_READY;
   wire tx_take = TX_VALID && TX_READY;
   wire exec    = state == AFIC_EXEC;

   always_comb begin
      next_state = state;
      case (state)
         AFIC_RX: begin
            if (rx_take && rx_cnt == `AFIC_LAST_BYTE) next_state = AFIC_EXEC;
         end
         AFIC_EXEC: begin
            next_state = (frm.target == MODULE_ADDR) ? AFIC_TX : AFIC_RX;
         end
         AFIC_TX: begin
            if (tx_take && tx_cnt == 4'd0) next_state = AFIC_RX;
         end
         default: next_state = AFIC_RX;
      endcase
   end

   // --------------------
   // frame receive
   // --------------------
   // bytes shift in first to last, so the struct lines up by field
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state    <= AFIC_RX;
         rx_cnt   <= 4'd0;
         frm      <= '0;
         RX_READY <= 1'b0;
      end else begin
         state    <= next_state;
         RX_READY <= next_state == AFIC_RX;
         if (rx_take) begin
            frm    <= {frm[63:0], RX_DATA};
            rx_cnt <= (rx_cnt == `AFIC_LAST_BYTE) ? 4'd0 : rx_cnt + 4'd1;
         end
      end
   end

   // --------------------
   // decode
   // --------------------
   wire addr_ok  = frm.target == MODULE_ADDR;
   wire sum_ok   = byte_sum(frm) == frm.sum;
   wire is_axis  = frm.instr == `AFIC_OP_ACCU_AXIS;
   wire is_glob  = frm.instr == `AFIC_OP_ACCU_GLOB;
   wire is_clr   = frm.instr == `AFIC_OP_FLAG_CLR;
   wire is_on    = frm.instr == `AFIC_OP_IRQ_ON;
   wire is_off   = frm.instr == `AFIC_OP_IRQ_OFF;
   wire is_calc  = frm.instr == `AFIC_OP_ACCU_X;
   wire is_gl    = frm.ctype == `AFIC_IRQ_GLOBAL;
   wire known    = is_axis | is_glob | is_clr | is_on | is_off | is_calc;
   // division is not built: too costly for a single-cycle step
   wire calc_ok  = frm.ctype <= `AFIC_CALC_SWAP && frm.ctype != `AFIC_CALC_DIV
                   && frm.ctype != `AFIC_CALC_MOD;
   wire irq_ok   = is_gl || 32'(frm.ctype) < IRQ_COUNT;
   wire bank_ok  = frm.motor[7:2] == 6'd0;
   wire type_ok  = ((is_axis | is_glob) & bank_ok)
                 | (is_clr & (frm.ctype <= `AFIC_FLAG_MAXTYPE))
                 | ((is_on | is_off) & irq_ok)
                 | (is_calc & calc_ok);
   wire [7:0] status = !sum_ok  ? `AFIC_ST_BAD_SUM
                     : !known   ? `AFIC_ST_BAD_CMD
                     : !type_ok ? `AFIC_ST_BAD_TYPE
                     : `AFIC_ST_OK;
   wire good     = exec && addr_ok && status == `AFIC_ST_OK;
   wire do_axis  = good & is_axis;
   wire do_glob  = good & is_glob;
   wire do_clr   = good & is_clr;
   wire do_on    = good & is_on;
   wire do_off   = good & is_off;
   wire do_calc  = good & is_calc;

   // --------------------
   // accumulator and X math
   // --------------------
   wire [7:0]  op = frm.ctype;
   wire [31:0] calc_acc = (op == `AFIC_CALC_ADD)  ? accu + xreg
                        : (op == `AFIC_CALC_SUB)  ? accu - xreg
                        : (op == `AFIC_CALC_MUL)  ? accu * xreg
                        : (op == `AFIC_CALC_AND)  ? accu & xreg
                        : (op == `AFIC_CALC_OR)   ? accu | xreg
                        : (op == `AFIC_CALC_XOR)  ? accu ^ xreg
                        : (op == `AFIC_CALC_NOT)  ? ~xreg
                        : (op == `AFIC_CALC_SWAP) ? xreg
                        : accu;
   wire        x_gets_a = op == `AFIC_CALC_LOAD || op == `AFIC_CALC_SWAP;
   wire [31:0] reply_val = do_calc ? calc_acc : accu;

   // ------------------------------------------------------------
   // register bus write path
   // ------------------------------------------------------------
   wire aw_take  = S_AXI_AWVALID && S_AXI_AWREADY;
   wire w_take   = S_AXI_WVALID && S_AXI_WREADY;
   wire wr_fire  = aw_full && w_full && !S_AXI_BVALID;
   wire wr_accu  = wr_fire && reg_hit(aw_addr, `AFIC_OFF_ACCU);
   wire wr_xreg  = wr_fire && reg_hit(aw_addr, `AFIC_OFF_XREG);
   wire wr_paddr = wr_fire && reg_hit(aw_addr, `AFIC_OFF_PADDR);
   wire wr_stat  = wr_fire && reg_hit(aw_addr, `AFIC_OFF_STAT);
   wire wr_mask  = wr_fire && reg_hit(aw_addr, `AFIC_OFF_MASK);
   wire wr_map   = aw_addr <= `AFIC_OFF_MASK;
   wire next_awf = aw_take | (aw_full & ~wr_fire);
   wire next_wf  = w_take | (w_full & ~wr_fire);
   wire next_bv  = wr_fire | (S_AXI_BVALID & ~S_AXI_BREADY);
   wire [31:0] w_new = strb_merge(32'h0, w_data, w_strb);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= `AFIC_RESP_OKAY;
      end else begin
         aw_full       <= next_awf;
         w_full        <= next_wf;
         S_AXI_AWREADY <= !next_awf && !next_bv;
         S_AXI_WREADY  <= !next_wf && !next_bv;
         S_AXI_BVALID  <= next_bv;
         if (aw_take) aw_addr <= S_AXI_AWADDR;
         if (w_take) begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (wr_fire) S_AXI_BRESP <= wr_map ? `AFIC_RESP_OKAY : `AFIC_RESP_SLVERR;
      end
   end

   // a command in its execute cycle wins over a bus write to the same word
   always_ff @(posedge CLK) begin
      if (RESET) begin
         accu  <= `AFIC_ACCU_RST;
         xreg  <= `AFIC_XREG_RST;
         paddr <= 11'h000;
         mask  <= 3'b000;
      end else begin
         if (do_calc) accu <= calc_acc;
         else if (wr_accu) accu <= strb_merge(accu, w_data, w_strb);
         if (do_calc && x_gets_a) xreg <= accu;
         else if (wr_xreg) xreg <= strb_merge(xreg, w_data, w_strb);
         if (wr_paddr) paddr <= w_new[10:0];
         if (wr_mask) mask <= w_new[2:0];
      end
   end

   // ------------------------------------------------------------
   // parameter store: {global, bank[1:0], number[7:0]}
   // ------------------------------------------------------------
   wire        mem_we    = do_axis | do_glob;
   wire [10:0] mem_waddr = {do_glob, frm.motor[1:0], frm.ctype};

   afic_param_mem #(
      .AW (11),
      .DW (32)
   ) u_mem (
      .CLK   (CLK),
      .RESET (RESET),
      .WE    (mem_we),
      .WADDR (mem_waddr),
      .WDATA (accu),
      .RADDR (paddr),
      .RDATA (pdata)
   );

   // ------------------------------------------------------------
   // error flags
   // ------------------------------------------------------------
   // type 0 selects all, types 1..5 one flag each
   wire [4:0] clr_sel  = (frm.ctype == 8'h00) ? 5'h1f
                       : 5'(5'h01 << (frm.ctype[2:0] - 3'd1));
   wire [4:0] flag_clr = do_clr ? clr_sel : 5'h00;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         flag_meta <= 5'h00;
         flag_sync <= 5'h00;
      end else begin
         flag_meta <= FLAG_EVENT;
         flag_sync <= flag_meta;
      end
   end

   // a flag raised in its clear cycle stays set
   for (genvar i = 0; i < `AFIC_FLAG_COUNT; i++) begin : g_flag
      always_ff @(posedge CLK) begin
         if (RESET) begin
            ERR_FLAGS[i] <= 1'b0;
         end else begin
            ERR_FLAGS[i] <= flag_sync[i] | (ERR_FLAGS[i] & ~flag_clr[i]);
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt enables
   // ------------------------------------------------------------
   wire [IRQ_COUNT-1:0] irq_sel = {{(IRQ_COUNT-1){1'b0}}, 1'b1} << frm.ctype;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         irq_en        <= '0;
         INT_GLOBAL_EN <= 1'b0;
      end else begin
         if (do_on && is_gl) INT_GLOBAL_EN <= 1'b1;
         else if (do_off && is_gl) INT_GLOBAL_EN <= 1'b0;
         if (do_on && !is_gl) irq_en <= irq_en | irq_sel;
         else if (do_off && !is_gl) irq_en <= irq_en & ~irq_sel;
      end
   end

   // ------------------------------------------------------------
   // event status and bus interrupt
   // ------------------------------------------------------------
   logic [2:0] ev;
   assign ev[`AFIC_EV_DONE] = good;
   assign ev[`AFIC_EV_SUM]  = exec && addr_ok && !sum_ok;
   assign ev[`AFIC_EV_FLAG] = |(flag_sync & ~ERR_FLAGS);
   wire [2:0] stat_clr = wr_stat ? w_new[2:0] : 3'b000;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         stat <= 3'b000;
         IRQ  <= 1'b0;
      end else begin
         stat <= (stat & ~stat_clr) | ev;
         IRQ  <= |(stat & mask);
      end
   end

   // ------------------------------------------------------------
   // register bus read path
   // ------------------------------------------------------------
   wire        ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
   wire        next_rv = ar_take | (S_AXI_RVALID & ~S_AXI_RREADY);
   wire [7:0]  ra      = S_AXI_ARADDR;
   wire        rd_map  = ra <= `AFIC_OFF_MASK;
   wire [31:0] rd_data = reg_hit(ra, `AFIC_OFF_ACCU)   ? accu
                       : reg_hit(ra, `AFIC_OFF_XREG)   ? xreg
                       : reg_hit(ra, `AFIC_OFF_FLAGS)  ? {27'h0, ERR_FLAGS}
                       : reg_hit(ra, `AFIC_OFF_IRQEN)  ? 32'(irq_en)
                       : reg_hit(ra, `AFIC_OFF_GLOBAL) ? {31'h0, INT_GLOBAL_EN}
                       : reg_hit(ra, `AFIC_OFF_PADDR)  ? {21'h0, paddr}
                       : reg_hit(ra, `AFIC_OFF_PDATA)  ? pdata
                       : reg_hit(ra, `AFIC_OFF_STAT)   ? {29'h0, stat}
                       : reg_hit(ra, `AFIC_OFF_MASK)   ? {29'h0, mask}
                       : 32'h0;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0;
         S_AXI_RRESP   <= `AFIC_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !next_rv;
         S_AXI_RVALID  <= next_rv;
         if (ar_take) begin
            S_AXI_RDATA <= rd_data;
            S_AXI_RRESP <= rd_map ? `AFIC_RESP_OKAY : `AFIC_RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------
   // reply transmit
   // ------------------------------------------------------------
   afic_reply_t reply;
   always_comb begin
      reply             = '0;
      reply.host        = HOST_ADDR;
      reply.module_addr = MODULE_ADDR;
      reply.status      = status;
      reply.instr       = frm.instr;
      reply.value       = reply_val;
      reply.sum         = byte_sum(reply);
   end

   // frames for another address get no reply at all
   always_ff @(posedge CLK) begin
      if (RESET) begin
         TX_DATA  <= 8'h00;
         TX_VALID <= 1'b0;
         tx_buf   <= 64'h0;
         tx_cnt   <= 4'd0;
      end else begin
         TX_VALID <= next_state == AFIC_TX;
         if (exec && addr_ok) begin
            TX_DATA <= reply[71:64];
            tx_buf  <= reply[63:0];
            tx_cnt  <= `AFIC_LAST_BYTE;
         end else if (tx_take && tx_cnt != 4'd0) begin
            TX_DATA <= tx_buf[63:56];
            tx_buf  <= {tx_buf[55:0], 8'h00};
            tx_cnt  <= tx_cnt - 4'd1;
         end
      end
   end
endmodule : afic_top
`default_nettype wire

// >>> dv/afic_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module afic_host_model (
   input  wire logic                  CLK,
   input  wire logic                  go,
   input  wire logic                  slow,
   input  wire afic_pkg::afic_frame_t frm,
   output logic                       done,
   output afic_pkg::afic_reply_t      rep,
   output afic_pkg::afic_byte_t       rx_data,
   output logic                       rx_valid,
   input  wire logic                  rx_ready,
   input  wire afic_pkg::afic_byte_t  tx_data,
   input  wire logic                  tx_valid,
   output logic                       tx_ready
);
   import afic_pkg::*;
   logic [71:0] r;
   initial begin
      {done, rep, rx_data, rx_valid, tx_ready} = '0;
      forever begin
         @(negedge CLK);
         if (go && !done) begin
            @(posedge CLK);
            for (int i = 0; i < 9; i++) begin
               rx_valid <= 1'b1;
               rx_data <= frm[71-8*i -: 8];
               do @(posedge CLK); while (!rx_ready);
            end
            rx_valid <= 1'b0;
            rx_data <= ~frm[7:0];
            for (int i = 0; i < 9; i++) begin
               if (slow) repeat (2) @(posedge CLK);
               tx_ready <= 1'b1;
               do @(posedge CLK); while (!(tx_valid && tx_ready));
               r = {r[63:0], tx_data};
               if (slow || i == 8) tx_ready <= 1'b0;
            end
            rep <= r;
            done <= 1'b1;
            do @(negedge CLK); while (go);
            @(posedge CLK);
            done <= 1'b0;
         end
      end
   end
endmodule : afic_host_model
`default_nettype wire

// >>> dv/afic_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module afic_top_sva #(
   parameter logic [7:0] HOST_ADDR = 8'h02
) (
   input wire logic       CLK,
   input wire logic       RESET,
   input wire logic       RX_VALID,
   input wire logic       RX_READY,
   input wire logic [7:0] TX_DATA,
   input wire logic       TX_VALID,
   input wire logic       TX_READY,
   input wire logic [4:0] FLAG_EVENT,
   input wire logic [4:0] ERR_FLAGS,
   input wire logic       INT_GLOBAL_EN,
   input wire logic       S_AXI_BVALID,
   input wire logic       S_AXI_BREADY,
   input wire logic       S_AXI_ARVALID,
   input wire logic       S_AXI_ARREADY,
   input wire logic       S_AXI_RVALID
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   logic [3:0] rx_cnt;
   always_ff @(posedge CLK) begin
      if (RESET) rx_cnt <= 4'h0;
      else if (RX_VALID && RX_READY) rx_cnt <= (rx_cnt == 4'h8) ? 4'h0 : rx_cnt + 4'h1;
   end
   reply_follows_a:
   assert property (RX_VALID && RX_READY && rx_cnt == 4'h8 |=> !RX_READY ##[1:2]
      (TX_VALID && TX_DATA == HOST_ADDR)) else $error("no reply after frame");
   rx_block_a:
   assert property (TX_VALID |-> !RX_READY) else $error("frame taken during reply");
   tx_hold_a:
   assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("reply byte dropped");
   flag_sticky_a:
   assert property (|(~ERR_FLAGS & $past(ERR_FLAGS)) |-> $rose(TX_VALID))
      else $error("flag fell without command");
   flag_set_a:
   assert property (FLAG_EVENT[4] [*5] |-> ERR_FLAGS[4]) else $error("flag not set");
   gie_cmd_a:
   assert property ($changed(INT_GLOBAL_EN) |-> $rose(TX_VALID))
      else $error("global enable moved alone");
   b_hold_a:
   assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
   r_next_a:
   assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read late");
endmodule : afic_top_sva
bind afic_top afic_top_sva #(.HOST_ADDR(HOST_ADDR)) u_afic_top_sva (.*);
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import afic_pkg::*;
   logic        clk = 1'b0, reset = 1'b1, go = 1'b0, slow = 1'b0, done;
   afic_byte_t  rx_data, tx_data;
   logic        rx_valid, rx_ready, tx_valid, tx_ready, int_en, irq;
   logic [4:0]  flag_ev = 5'h00, err_flags;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   afic_frame_t frm = '0;
   afic_reply_t rep;
   int          errors = 0, checked = 0, cycles = 0;
   afic_top u_afic_top (.CLK(clk), .RESET(reset), .RX_DATA(rx_data), .RX_VALID(rx_valid),
      .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
      .FLAG_EVENT(flag_ev), .ERR_FLAGS(err_flags), .INT_GLOBAL_EN(int_en), .IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   afic_host_model u_afic_host_model (.CLK(clk), .go(go), .slow(slow), .frm(frm), .done(done),
      .rep(rep), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   always #2 clk = ~clk;
   // ------------
   // shared bus and frame tasks
   // ------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid} <= 2'b11;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
   endtask : wr
   task automatic rd32(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rsp = rresp;
   endtask : rd32
   task automatic cmd(input afic_byte_t ins, ty, mo = 8'h00, input logic [31:0] v = 32'h0,
                      input logic bad = 1'b0, input afic_byte_t st = 8'h64);
      afic_byte_t s;
      s = 8'h01 + ins + ty + mo + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      frm <= {8'h01, ins, ty, mo, v, s + {7'h0, bad}};
      go <= 1'b1;
      do @(posedge clk); while (!done);
      go <= 1'b0;
      chk("status", 32'(st), 32'(rep.status));
      chk("header", {16'h0201, ins, 8'h0}, {rep[71:56], rep.instr, 8'h0});
      s = 8'h00;
      for (int i = 1; i < 9; i++) s += rep[8*i +: 8];
      chk("reply sum", 32'(s), 32'(rep.sum));
      repeat (3) @(posedge clk);
   endtask : cmd
   task automatic raise;
      flag_ev <= 5'h1f;
      repeat (6) @(posedge clk);
      flag_ev <= 5'h00;
      repeat (4) @(posedge clk);
      chk("flags set", 32'h1f, 32'(err_flags));
   endtask : raise
   // ------------
   // scenarios
   // ------------
   task automatic t_calc;
      wr(8'h00, 32'h7);
      wr(8'h04, 32'h6);
      cmd(8'h21, 8'h02);
      chk("product", 32'h2a, rep.value);
      rd32(8'h00);
      chk("accu", 32'h2a, rd);
      $display("test calc done");
   endtask : t_calc
   task automatic t_copy;
      cmd(8'h22, 8'h05, 8'h01);
      cmd(8'h23, 8'h2a, 8'h02);
      wr(8'h14, 32'h105);
      rd32(8'h18);
      chk("axis param", 32'h2a, rd);
      wr(8'h14, 32'h62a);
      rd32(8'h18);
      chk("global param", 32'h2a, rd);
      $display("test copy done");
   endtask : t_copy
   task automatic t_flags;
      logic [4:0] ex;
      ex = 5'h1f;
      raise();
      for (int t = 1; t < 6; t++) begin
         cmd(8'h24, 8'(t));
         ex[t-1] = 1'b0;
         chk("flags", 32'(ex), 32'(err_flags));
      end
      raise();
      cmd(8'h24, 8'h00, 8'h00, 32'hdead_beef);
      chk("flags all", 32'h0, 32'(err_flags));
      $display("test flags done");
   endtask : t_flags
   task automatic t_irq_cmd;
      slow <= 1'b1;
      cmd(8'h19, 8'hff);
      chk("global on", 32'h1, 32'(int_en));
      cmd(8'h19, 8'h03);
      rd32(8'h0c);
      chk("enable", 32'h8, rd);
      cmd(8'h1a, 8'h03);
      rd32(8'h0c);
      chk("disable", 32'h0, rd);
      cmd(8'h1a, 8'hff);
      chk("global off", 32'h0, 32'(int_en));
      slow <= 1'b0;
      $display("test irq commands done");
   endtask : t_irq_cmd
   task automatic t_intr;
      cmd(8'h21, 8'h00, 8'h00, 32'h0, 1'b1, 8'h01);
      chk("masked", 32'h0, 32'(irq));
      rd32(8'h00);
      chk("accu kept", 32'h2a, rd);
      rd32(8'h1c);
      chk("sum event", 32'h2, rd & 32'h2);
      wr(8'h20, 32'h2);
      repeat (2) @(posedge clk);
      chk("irq high", 32'h1, 32'(irq));
      wr(8'h1c, 32'hffff_ffff);
      repeat (2) @(posedge clk);
      chk("irq low", 32'h0, 32'(irq));
      chk("write resp", 32'h0, 32'(rsp));
      rd32(8'h40);
      chk("unmapped", 32'h2, 32'(rsp));
      wr(8'h40, 32'h0);
      chk("bad write", 32'h2, 32'(rsp));
      $display("test interrupt done");
   endtask : t_intr
   task automatic summarize;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      t_calc();
      t_copy();
      t_flags();
      t_irq_cmd();
      t_intr();
      summarize();
   end
endmodule : tb
`default_nettype wire

// >>> include/afic_defs.svh
`ifndef AFIC_DEFS_SVH
`define AFIC_DEFS_SVH
// --------------------
// frame and opcodes
// --------------------
`define AFIC_LAST_BYTE    4'd8
`define AFIC_OP_ACCU_AXIS 8'h22
`define AFIC_OP_ACCU_GLOB 8'h23
`define AFIC_OP_FLAG_CLR  8'h24
`define AFIC_OP_IRQ_ON    8'h19
`define AFIC_OP_IRQ_OFF   8'h1a
`define AFIC_OP_ACCU_X    8'h21
`define AFIC_IRQ_GLOBAL   8'hff
`define AFIC_ST_OK        8'h64
`define AFIC_ST_BAD_SUM   8'h01
`define AFIC_ST_BAD_CMD   8'h02
`define AFIC_ST_BAD_TYPE  8'h03
`define AFIC_CALC_ADD     8'h00
`define AFIC_CALC_SUB     8'h01
`define AFIC_CALC_MUL     8'h02
`define AFIC_CALC_DIV     8'h03
`define AFIC_CALC_MOD     8'h04
`define AFIC_CALC_AND     8'h05
`define AFIC_CALC_OR      8'h06
`define AFIC_CALC_XOR     8'h07
`define AFIC_CALC_NOT     8'h08
`define AFIC_CALC_LOAD    8'h09
`define AFIC_CALC_SWAP    8'h0a
`define AFIC_FLAG_COUNT   5
`define AFIC_FLAG_MAXTYPE 8'h05
// --------------------
// register map
// --------------------
`define AFIC_OFF_ACCU     8'h00
`define AFIC_OFF_XREG     8'h04
`define AFIC_OFF_FLAGS    8'h08
`define AFIC_OFF_IRQEN    8'h0c
`define AFIC_OFF_GLOBAL   8'h10
`define AFIC_OFF_PADDR    8'h14
`define AFIC_OFF_PDATA    8'h18
`define AFIC_OFF_STAT     8'h1c
`define AFIC_OFF_MASK     8'h20
`define AFIC_ACCU_RST     32'h0000_0000
`define AFIC_XREG_RST     32'h0000_0000
`define AFIC_EV_DONE      0
`define AFIC_EV_SUM       1
`define AFIC_EV_FLAG      2
`define AFIC_RESP_OKAY    2'b00
`define AFIC_RESP_SLVERR  2'b10
`endif

// >>> include/afic_pkg.sv
package afic_pkg;
   typedef logic [7:0] afic_byte_t;
   typedef struct packed {
      afic_byte_t  target;
      afic_byte_t  instr;
      afic_byte_t  ctype;
      afic_byte_t  motor;
      logic [31:0] value;
      afic_byte_t  sum;
   } afic_frame_t;
   typedef struct packed {
      afic_byte_t  host;
      afic_byte_t  module_addr;
      afic_byte_t  status;
      afic_byte_t  instr;
      logic [31:0] value;
      afic_byte_t  sum;
   } afic_reply_t;
   typedef enum logic [1:0] {AFIC_RX, AFIC_EXEC, AFIC_TX} afic_state_t;
endpackage : afic_pkg
